/* File: shared/btg_pkg.sv */
/*
 * Constants for the beep tone generator: register offsets, reset values,
 * field positions, channel-tie codes and oscillator/gain scaling.
 * Assumes an 8-bit register port with 7-bit offsets and a one-cycle
 * sample strobe at the DAC word rate, both synchronous to clk.
 */
// Summary of operation
// RULE1: Enable starts tone, self-clears after duration
// RULE2: Tone runs only in tone-capable mode
// RULE3: Software writes zero to reserved bit six
// RULE4: Left level: code 0 +2 dB, 1 dB steps
// RULE5: Right level same scale, all-ones -61 dB
// RULE6: Tie field copies one channel's level over
// RULE7: Tone lasts exactly 24-bit sample count
// RULE8: Length resets to 0x0000EE
// RULE9: Sine coefficient resets to 0x10D8
// RULE10: Cosine coefficient resets to 0x7EE3
// RULE11: Software avoids reserved offsets 0x50 to 0x73
// RULE12: Recursive oscillator plus down-counting length
package btg_pkg;
    // Register offsets
    localparam logic [6:0] OFS_LEFT = 7'h47;
    localparam logic [6:0] OFS_RIGHT = 7'h48;
    localparam logic [6:0] OFS_LEN_HI = 7'h49;
    localparam logic [6:0] OFS_LEN_MID = 7'h4a;
    localparam logic [6:0] OFS_LEN_LO = 7'h4b;
    localparam logic [6:0] OFS_SIN_HI = 7'h4c;
    localparam logic [6:0] OFS_SIN_LO = 7'h4d;
    localparam logic [6:0] OFS_COS_HI = 7'h4e;
    localparam logic [6:0] OFS_COS_LO = 7'h4f;
    // Reset values
    localparam logic [7:0] RST_LEFT = 8'h00;
    localparam logic [7:0] RST_RIGHT = 8'h00;
    localparam logic [7:0] RST_LEN_HI = 8'h00;
    localparam logic [7:0] RST_LEN_MID = 8'h00;
    localparam logic [7:0] RST_LEN_LO = 8'hee;
    localparam logic [7:0] RST_SIN_HI = 8'h10;
    localparam logic [7:0] RST_SIN_LO = 8'hd8;
    localparam logic [7:0] RST_COS_HI = 8'h7e;
    localparam logic [7:0] RST_COS_LO = 8'he3;
    localparam logic [7:0] RD_NONE = 8'h00;
    // Field positions
    localparam int EN_BIT = 7;
    localparam int LVL_MSB = 5;
    localparam int TIE_MSB = 7;
    localparam int TIE_LSB = 6;
    // Channel-tie codes
    localparam logic [1:0] TIE_LEFT_FROM_RIGHT = 2'h1;
    localparam logic [1:0] TIE_RIGHT_FROM_LEFT = 2'h2;
    // Length counter values
    localparam logic [23:0] CNT_ZERO = 24'h00_0000;
    localparam logic [23:0] CNT_ONE = 24'h00_0001;
    localparam logic [15:0] SAMPLE_ZERO = 16'h0000;
    // Oscillator coefficients are Q1.15; doubling folds into the shift
    localparam int OSC_SHIFT = 14;
    // Gain: mantissa for +2..-3 dB in Q2.14, then one halving per 6 dB
    localparam int GAIN_FRAC = 14;
    localparam int DB_PER_OCT = 6;
    localparam logic [15:0] GAIN_M0 = 16'h5092;
    localparam logic [15:0] GAIN_M1 = 16'h47cf;
    localparam logic [15:0] GAIN_M2 = 16'h4000;
    localparam logic [15:0] GAIN_M3 = 16'h390a;
    localparam logic [15:0] GAIN_M4 = 16'h32d6;
    localparam logic [15:0] GAIN_M5 = 16'h2d4f;
    localparam logic [5:0] LVL_UNITY = 6'h02;
    localparam logic [5:0] LVL_HALF = 6'h08;
    localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
    localparam logic signed [15:0] SAT_MIN = -16'sh8000;
endpackage : btg_pkg

/* File: rtl/btg_scaler.sv */
/*
 * Beep level scaler: applies a 6-bit 1 dB-step attenuation code to one
 * signed sample. Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ns
module btg_scaler (
    // Sample in and level code
    input wire logic signed [15:0] sample,
    input wire logic [5:0] level,
    // Scaled, saturated sample
    output logic signed [15:0] scaled
);
    import btg_pkg::*;

    logic [15:0] mant; // Mantissa for level modulo six
    logic [5:0] octave; // Number of 6 dB halvings
    logic [5:0] step; // Level modulo six
    logic signed [32:0] prod; // Full product
    logic signed [32:0] shifted; // Product after scaling shifts

    // Split code into octave and step, pick mantissa, scale, saturate
    always_comb begin
        octave = level / 6'(DB_PER_OCT); // see RULE4 see RULE5
        step = level - 6'(octave * 6'(DB_PER_OCT));
        case (step)
            6'd0: mant = GAIN_M0;
            6'd1: mant = GAIN_M1;
            6'd2: mant = GAIN_M2;
            6'd3: mant = GAIN_M3;
            6'd4: mant = GAIN_M4;
            default: mant = GAIN_M5;
        endcase
        prod = 33'(sample) * $signed({1'b0, mant});
        shifted = prod >>> (GAIN_FRAC + int'(octave));
        // Clip the +2 dB end so a full-scale tone cannot wrap
        if (shifted > 33'(SAT_MAX)) begin
            scaled = SAT_MAX;
        end else if (shifted < 33'(SAT_MIN)) begin
            scaled = SAT_MIN;
        end else begin
            scaled = shifted[15:0];
        end
    end
endmodule : btg_scaler

/* File: rtl/btg_beep_gen.sv */
/*
 * Beep tone generator: register file at offsets 0x47..0x4f, recursive
 * sine oscillator stepped once per DAC word strobe, length counter that
 * self-clears the enable bit, and per-channel level with channel tie.
 * Assumes sample_tick is a one-cycle strobe at the DAC word rate and all
 * inputs are synchronous to clk.
 */
`timescale 1ns/1ns
module btg_beep_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Processing path
    input wire logic sample_tick,
    input wire logic tone_capable_processing_mode,
    output logic signed [15:0] left_sample,
    output logic signed [15:0] right_sample,
    output logic sample_valid,
    output logic tone_active
);
    import btg_pkg::*;

    // All block state
    typedef struct packed {
        logic [7:0] left; // beep_enable_left_level
        logic [7:0] right; // beep_tie_right_level
        logic [7:0] len_hi; // beep_length_high
        logic [7:0] len_mid; // beep_length_middle
        logic [7:0] len_lo; // beep_length_low
        logic [7:0] sin_hi; // tone_sine_high
        logic [7:0] sin_lo; // tone_sine_low
        logic [7:0] cos_hi; // tone_cosine_high
        logic [7:0] cos_lo; // tone_cosine_low
        logic [23:0] cnt; // Samples still to produce
        logic signed [15:0] y1; // Current oscillator sample
        logic signed [15:0] y2; // Previous oscillator sample
        logic signed [15:0] lout; // Left output sample
        logic signed [15:0] rout; // Right output sample
        logic valid; // Output sample strobe
        logic [7:0] rdata; // Read data
    } btg_state_t;

    btg_state_t st; // Registered state
    btg_state_t next_st; // Next state
    logic en; // Enable bit as stored
    logic [5:0] lcode; // Effective left level code
    logic [5:0] rcode; // Effective right level code
    logic signed [15:0] lscaled; // Left scaled sample
    logic signed [15:0] rscaled; // Right scaled sample
    logic signed [15:0] cosc; // Cosine coefficient
    logic signed [31:0] cprod; // Cosine times current sample
    logic signed [15:0] ynew; // Next oscillator sample
    logic step_now; // Oscillator steps this cycle
    logic start; // Software sets the enable bit
    logic signed [15:0] sinc; // Sine coefficient, oscillator seed

    assign en = st.left[EN_BIT];
    assign cosc = {st.cos_hi, st.cos_lo};
    assign sinc = {st.sin_hi, st.sin_lo};
    assign cprod = cosc * st.y1;
    // 2*c*y[n-1] - y[n-2], coefficient in Q1.15
    assign ynew = 16'(cprod >>> OSC_SHIFT) - st.y2; // see RULE12
    assign step_now = en && sample_tick && tone_capable_processing_mode;
    assign start = reg_wr && reg_addr == OFS_LEFT && reg_wdata[EN_BIT];

    // Channel tie selection of level codes
    always_comb begin
        lcode = st.left[LVL_MSB:0];
        rcode = st.right[LVL_MSB:0];
        case (st.right[TIE_MSB:TIE_LSB])
            TIE_LEFT_FROM_RIGHT: lcode = st.right[LVL_MSB:0]; // see RULE6
            TIE_RIGHT_FROM_LEFT: rcode = st.left[LVL_MSB:0]; // see RULE6
            default: begin
                lcode = st.left[LVL_MSB:0];
                rcode = st.right[LVL_MSB:0];
            end
        endcase
    end

    // Left level scaler
    btg_scaler u_scale_left (
        .sample(st.y1),
        .level(lcode),
        .scaled(lscaled)
    );

    // Right level scaler
    btg_scaler u_scale_right (
        .sample(st.y1),
        .level(rcode),
        .scaled(rscaled)
    );

    // Next-state logic: oscillator, counter, register writes and reads
    always_comb begin
        next_st = st;
        next_st.valid = 1'b0;
        // Produce one sample per word strobe while enabled and allowed
        if (step_now) begin // see RULE2
            if (st.cnt == CNT_ZERO) begin
                next_st.left[EN_BIT] = 1'b0; // see RULE1
            end else begin
                next_st.lout = lscaled; // see RULE4
                next_st.rout = rscaled; // see RULE5
                next_st.valid = 1'b1;
                next_st.y2 = st.y1;
                next_st.y1 = ynew; // see RULE12
                next_st.cnt = st.cnt - CNT_ONE; // see RULE7
                // Last sample done: enable clears itself
                if (st.cnt == CNT_ONE) begin
                    next_st.left[EN_BIT] = 1'b0; // see RULE1
                end
            end
        end
        // Register writes; a software write wins over the self-clear
        if (reg_wr) begin
            case (reg_addr)
                OFS_LEFT: next_st.left = reg_wdata;
                OFS_RIGHT: next_st.right = reg_wdata;
                OFS_LEN_HI: next_st.len_hi = reg_wdata;
                OFS_LEN_MID: next_st.len_mid = reg_wdata;
                OFS_LEN_LO: next_st.len_lo = reg_wdata;
                OFS_SIN_HI: next_st.sin_hi = reg_wdata;
                OFS_SIN_LO: next_st.sin_lo = reg_wdata;
                OFS_COS_HI: next_st.cos_hi = reg_wdata;
                OFS_COS_LO: next_st.cos_lo = reg_wdata;
                // Unmapped offsets: write ignored, self-clear kept
                default: begin
                end
            endcase
        end
        // Enable written high: seed oscillator and load the length
        if (start) begin
            next_st.cnt = {st.len_hi, st.len_mid, st.len_lo}; // see RULE12
            next_st.y1 = sinc; // see RULE9
            next_st.y2 = SAMPLE_ZERO;
        end
        // Read data captured on a read strobe; unmapped reads give zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_LEFT: next_st.rdata = st.left;
                OFS_RIGHT: next_st.rdata = st.right;
                OFS_LEN_HI: next_st.rdata = st.len_hi;
                OFS_LEN_MID: next_st.rdata = st.len_mid;
                OFS_LEN_LO: next_st.rdata = st.len_lo;
                OFS_SIN_HI: next_st.rdata = st.sin_hi;
                OFS_SIN_LO: next_st.rdata = st.sin_lo;
                OFS_COS_HI: next_st.rdata = st.cos_hi;
                OFS_COS_LO: next_st.rdata = st.cos_lo;
                default: next_st.rdata = RD_NONE;
            endcase
        end
    end

    // State register with documented reset values
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.left <= RST_LEFT;
            st.right <= RST_RIGHT;
            st.len_hi <= RST_LEN_HI; // see RULE8
            st.len_mid <= RST_LEN_MID; // see RULE8
            st.len_lo <= RST_LEN_LO; // see RULE8
            st.sin_hi <= RST_SIN_HI; // see RULE9
            st.sin_lo <= RST_SIN_LO; // see RULE9
            st.cos_hi <= RST_COS_HI; // see RULE10
            st.cos_lo <= RST_COS_LO; // see RULE10
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = st.rdata;
    assign left_sample = st.lout;
    assign right_sample = st.rout;
    assign sample_valid = st.valid;
    assign tone_active = en;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_self_clear_end: assert property ( // see RULE1
        step_now && st.cnt == CNT_ONE && !start |=> !en)
        else $error("enable did not clear after last sample");
    chk_valid_cause: assert property ( // see RULE1
        sample_valid |-> $past(en) && $past(sample_tick))
        else $error("sample produced without enable and strobe");
    chk_mode_gate: assert property ( // see RULE2
        sample_tick && !tone_capable_processing_mode |=> !sample_valid)
        else $error("sample produced outside tone-capable mode");
    chk_count_step: assert property ( // see RULE7
        step_now && st.cnt != CNT_ZERO && !start
        |=> st.cnt == $past(st.cnt) - CNT_ONE && sample_valid)
        else $error("length counter did not step with a sample");
    chk_length_reset: assert property ( // see RULE8
        $fell(srst) |-> {st.len_hi, st.len_mid, st.len_lo} == 24'h00_00ee)
        else $error("length reset value wrong");
    chk_coef_reset: assert property ( // see RULE9 see RULE10
        $fell(srst) |-> {st.sin_hi, st.sin_lo} == 16'h10d8
            && {st.cos_hi, st.cos_lo} == 16'h7ee3)
        else $error("coefficient reset value wrong");
    chk_tie_left: assert property ( // see RULE6
        st.right[TIE_MSB:TIE_LSB] == TIE_LEFT_FROM_RIGHT
        |-> lcode == st.right[LVL_MSB:0] && rcode == lcode)
        else $error("left level not tied to right");
    chk_tie_right: assert property ( // see RULE6
        st.right[TIE_MSB:TIE_LSB] == TIE_RIGHT_FROM_LEFT
        |-> rcode == st.left[LVL_MSB:0] && lcode == rcode)
        else $error("right level not tied to left");
    chk_osc_seed: assert property ( // see RULE12
        start |=> st.y1 == $past(sinc)
            && st.y2 == SAMPLE_ZERO && en)
        else $error("oscillator not seeded on start");
    chk_unity_gain: assert property ( // see RULE4
        lcode == LVL_UNITY |-> lscaled == st.y1)
        else $error("0 dB code does not pass sample unchanged");
    chk_six_db_step: assert property ( // see RULE5
        rcode == LVL_HALF |-> rscaled == (st.y1 >>> 1))
        else $error("-6 dB code does not halve sample");

    cov_beep_done: cover property (en ##1 !en);
    cov_tied_left: cover property (
        sample_valid && st.right[TIE_MSB:TIE_LSB] == TIE_LEFT_FROM_RIGHT);
    cov_mode_off: cover property (
        en && sample_tick && !tone_capable_processing_mode);
    cov_restart: cover property (en && start);
endmodule : btg_beep_gen

/* File: tb/btg_dac_path_model.sv */
/*
 * Model of the DAC channel path that sits after the beep generator.
 * Assumes clk is the design clock; strobes change on the falling edge.
 */
`timescale 1ns/1ns
module btg_dac_path_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bench control
    input wire logic run,
    input wire logic mode_sel,
    input wire logic clr,
    // Samples from the generator
    input wire logic signed [15:0] left_sample,
    input wire logic signed [15:0] right_sample,
    input wire logic sample_valid,
    // Word strobe and mode toward the generator
    output logic sample_tick,
    output logic tone_capable_processing_mode,
    // Observed results
    output int n_valid,
    output logic signed [15:0] first_left,
    output logic signed [15:0] first_right
);
    // Word strobe divider, one tick in four cycles
    logic [1:0] div = 2'h0;
    // Mode follows the bench selection directly
    assign tone_capable_processing_mode = mode_sel;
    // Strobe launched off the falling edge, away from sampling
    always @(negedge clk) begin
        div <= div + 2'h1;
        sample_tick <= run && (div == 2'h3);
    end
    // Count samples and keep the first pair of each beep
    always @(posedge clk) begin
        if (srst || clr) begin
            n_valid <= 0;
        end else if (sample_valid) begin
            if (n_valid == 0) begin
                first_left <= left_sample;
                first_right <= right_sample;
            end
            n_valid <= n_valid + 1;
        end
    end
endmodule : btg_dac_path_model

/* File: tb/test_btg_beep_gen.sv */
/*
 * Self-checking bench for the beep generator.
 * Assumes the design and package are compiled first.
 */
`timescale 1ns/1ns
module test_btg_beep_gen;
    import btg_pkg::*;
    // Design inputs and outputs
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sample_tick;
    logic mode;
    logic signed [15:0] left_sample;
    logic signed [15:0] right_sample;
    logic sample_valid;
    logic tone_active;
    // Partner control and results
    logic run = 1'b0;
    logic mode_sel = 1'b1;
    logic clr = 1'b0;
    int n_valid;
    logic signed [15:0] first_left;
    logic signed [15:0] first_right;
    // Scoreboard counters
    int mismatches = 0;
    int cmp_count = 0;

    btg_beep_gen dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_tick(sample_tick),
        .tone_capable_processing_mode(mode), .left_sample(left_sample),
        .right_sample(right_sample), .sample_valid(sample_valid),
        .tone_active(tone_active));
    btg_dac_path_model far (.clk(clk), .srst(srst), .run(run),
        .mode_sel(mode_sel), .clr(clr), .left_sample(left_sample),
        .right_sample(right_sample), .sample_valid(sample_valid),
        .sample_tick(sample_tick), .tone_capable_processing_mode(mode),
        .n_valid(n_valid), .first_left(first_left),
        .first_right(first_right));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // Compare and count
    task chk(input logic [15:0] got, input logic [15:0] exp,
             input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : chk

    // One register write, strobe for one cycle
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    // One register read, data valid one cycle after the strobe
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // Reset values of every register, then unmapped offsets that lie
    // outside the reserved span, which software must leave alone
    task test_reset_regs;
        logic [6:0] ofs [9];
        logic [7:0] rv [9];
        logic [7:0] d;
        ofs = '{OFS_LEFT, OFS_RIGHT, OFS_LEN_HI, OFS_LEN_MID, OFS_LEN_LO,
                OFS_SIN_HI, OFS_SIN_LO, OFS_COS_HI, OFS_COS_LO};
        rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e,
               8'he3};
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], d);
            chk({8'h00, d}, {8'h00, rv[i]}, "reset value");
        end
        wr(7'h46, 8'h5a);
        rd(7'h46, d);
        chk({8'h00, d}, {8'h00, RD_NONE}, "unmapped low");
        rd(7'h74, d);
        chk({8'h00, d}, {8'h00, RD_NONE}, "unmapped high");
        $display("test_reset_regs done at %0t", $time);
    endtask : test_reset_regs

    // Program, start, optionally pause by mode, then judge one beep
    task beep(input logic [23:0] len, input logic [7:0] lft,
              input logic [7:0] rgt, input logic [15:0] exp_n,
              input logic [15:0] exp_l, input logic [15:0] exp_r,
              input logic pause);
        int i;
        logic [7:0] d;
        i = 0;
        wr(OFS_LEN_HI, len[23:16]);
        wr(OFS_LEN_MID, len[15:8]);
        wr(OFS_LEN_LO, len[7:0]);
        wr(OFS_RIGHT, rgt);
        clr = 1'b1;
        mode_sel = !pause;
        wr(OFS_LEFT, {2'b10, lft[5:0]});
        clr = 1'b0;
        run = 1'b1;
        if (pause) begin
            repeat (40) @(negedge clk);
            chk(16'(n_valid), 16'h0000, "paused output");
            chk({15'h0, tone_active}, 16'h0001, "paused enable");
            mode_sel = 1'b1;
        end
        while (tone_active !== 1'b0 && i < 400) begin
            @(negedge clk);
            i++;
        end
        repeat (8) @(negedge clk);
        run = 1'b0;
        chk({15'h0, tone_active}, 16'h0000, "self clear");
        rd(OFS_LEFT, d);
        chk({8'h00, d}, {10'h000, lft[5:0]}, "enable bit");
        chk(16'(n_valid), exp_n, "sample count");
        if (exp_n != 16'h0000) begin
            chk(first_left, exp_l, "left level");
            chk(first_right, exp_r, "right level");
        end
    endtask : beep

    // Every tie code with left unity and right at half amplitude, then the +2 dB and -61 dB ends
    task test_levels;
        beep(24'h1, 8'h02, 8'h08, 16'h1, 16'h10d8, 16'h086c, 0);
        beep(24'h1, 8'h02, 8'h48, 16'h1, 16'h086c, 16'h086c, 0);
        beep(24'h1, 8'h02, 8'h88, 16'h1, 16'h10d8, 16'h10d8, 0);
        beep(24'h1, 8'h02, 8'hc8, 16'h1, 16'h10d8, 16'h086c, 0);
        beep(24'h1, 8'h00, 8'h3f, 16'h1, 16'h1534, 16'h0003, 0);
        $display("test_levels done at %0t", $time);
    endtask : test_levels

    // Exact counts, the empty count, and a mode pause before the first sample
    task test_length;
        beep(24'h5, 8'h02, 8'h02, 16'h5, 16'h10d8, 16'h10d8, 0);
        // Fifth sample, fourth recursion step from the reset coefficients, unity gain
        chk(left_sample, 16'h4e71, "left fifth sample");
        chk(right_sample, 16'h4e71, "right fifth sample");
        beep(24'h0, 8'h02, 8'h02, 16'h0, 16'h0, 16'h0, 0);
        beep(24'h3, 8'h08, 8'h02, 16'h3, 16'h086c, 16'h10d8, 1);
        $display("test_length done at %0t", $time);
    endtask : test_length

    // Counts, verdict and end of run
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Hang guard, 20000 cycles, far beyond the ~300 the tests need
    initial begin
        #80000;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        test_reset_regs();
        test_levels();
        test_length();
        final_report();
    end
endmodule : test_btg_beep_gen
